// ===== common/sdlp_pkg.sv
// Constants for the SDRAM low-power, interrupt and memory-type block.
// Assumes a 32-bit APB slave with word-aligned registers.
package sdlp_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFF_LOW_POWER_CONTROL = 8'h00;
	localparam logic [7:0] OFF_INTERRUPT_ENABLE = 8'h04;
	localparam logic [7:0] OFF_INTERRUPT_DISABLE = 8'h08;
	localparam logic [7:0] OFF_INTERRUPT_MASK = 8'h0c;
	localparam logic [7:0] OFF_INTERRUPT_STATUS = 8'h10;
	localparam logic [7:0] OFF_MEMORY_TYPE_SELECT = 8'h14;
	localparam logic [7:0] OFF_SELF_REFRESH_EXIT = 8'h18;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int LPS_LSB = 0;
	localparam int PAR_LSB = 4;
	localparam int TCR_LSB = 8;
	localparam int ODS_LSB = 10;
	localparam int TMO_LSB = 12;
	localparam int RFE_BIT = 0;
	localparam logic [31:0] LPC_RESET = 32'h0000_0000;
	localparam logic [31:0] LPC_WMASK = 32'h0000_3f73;
	localparam logic [1:0] MT_RESET = 2'h0;
	localparam logic [3:0] SRX_RESET = 4'h8;
	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	localparam logic [1:0] LPS_NONE = 2'h0;
	localparam logic [1:0] LPS_SELF = 2'h1;
	localparam logic [1:0] LPS_PDN = 2'h2;
	localparam logic [1:0] LPS_DEEP = 2'h3;
	localparam logic [1:0] MT_SDRAM = 2'h0;
	localparam logic [1:0] MT_LP_SDRAM = 2'h1;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int ENTRY_DELAY_SHORT_CYC = 64;
	localparam int ENTRY_DELAY_LONG_CYC = 128;
	localparam logic [7:0] ENTRY_SHORT = 8'(ENTRY_DELAY_SHORT_CYC);
	localparam logic [7:0] ENTRY_LONG = 8'(ENTRY_DELAY_LONG_CYC);
	// ----------------------------------------
	// Memory commands toward the sequencer
	// ----------------------------------------
	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_SELF_REFRESH,
		CMD_POWER_DOWN,
		CMD_DEEP_POWER_DOWN,
		CMD_EXIT
	} sdlp_cmd_e;
endpackage : sdlp_pkg

// ===== core/sdlp_ctrl.sv
// Low-power sequencing, refresh-error interrupt and memory-type select.
// Assumes APB master on pclk; sequencer reports access busy and accepts
// one-cycle low-power command requests.
//
// Functional notes
// - Select 00 issues no low-power commands
// - Select 01 self-refresh, clock stopped, enable low
// - Select 10 power-down after each access
// - Select 11 deep power-down, low-power memory
// - Partial-array refresh sent at initialization
// - Temperature refresh setting sent at initialization
// - Drive strength sent at initialization
// - Entry delay 0, 64, 128 cycles
// - Enable write of 1 sets mask
// - Disable write of 1 clears mask
// - Mask register reads enable state
// - Status bit set on error, read clears
// - Memory type 00 SDRAM, 01 low-power
// - Wait exit delay before activate
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module sdlp_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic access_busy,
	input wire logic access_req,
	input wire logic refresh_error,
	output logic access_grant,
	output sdlp_pkg::sdlp_cmd_e lp_cmd,
	output logic sdram_clock_out_en,
	output logic sdram_clock_enable,
	output logic [2:0] partial_array_refresh,
	output logic [1:0] temp_comp_refresh,
	output logic [1:0] output_drive_strength,
	output logic [1:0] memory_type,
	output logic irq
);
	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic wr_en;
	logic rd_en;
	logic [31:0] lpc_r;
	logic [1:0] mt_r;
	logic [3:0] srx_r;
	logic mask_r;
	logic stat_r;

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lpc_r <= sdlp_pkg::LPC_RESET;
			mt_r <= sdlp_pkg::MT_RESET;
			srx_r <= sdlp_pkg::SRX_RESET;
		end else if (wr_en) begin
			if (paddr == sdlp_pkg::OFF_LOW_POWER_CONTROL) begin
				lpc_r <= pwdata & sdlp_pkg::LPC_WMASK;
			end
			if (paddr == sdlp_pkg::OFF_MEMORY_TYPE_SELECT) begin
				mt_r <= pwdata[1:0];
			end
			if (paddr == sdlp_pkg::OFF_SELF_REFRESH_EXIT) begin
				srx_r <= pwdata[3:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_r <= 1'b0;
		end else if (wr_en && paddr == sdlp_pkg::OFF_INTERRUPT_ENABLE
			&& pwdata[sdlp_pkg::RFE_BIT]) begin
			mask_r <= 1'b1;
		end else if (wr_en && paddr == sdlp_pkg::OFF_INTERRUPT_DISABLE
			&& pwdata[sdlp_pkg::RFE_BIT]) begin
			mask_r <= 1'b0;
		end
	end

	// Set beats the read-clear so an error on the read cycle survives
	// Only a bit already returned is cleared: an error at setup is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= 1'b0;
		end else if (refresh_error) begin
			stat_r <= 1'b1;
		end else if (rd_en && paddr == sdlp_pkg::OFF_INTERRUPT_STATUS
			&& prdata[sdlp_pkg::RFE_BIT]) begin
			stat_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				sdlp_pkg::OFF_LOW_POWER_CONTROL: prdata <= lpc_r;
				sdlp_pkg::OFF_INTERRUPT_MASK: prdata <= {31'h0, mask_r};
				sdlp_pkg::OFF_INTERRUPT_STATUS: prdata <= {31'h0, stat_r};
				sdlp_pkg::OFF_MEMORY_TYPE_SELECT: prdata <= {30'h0, mt_r};
				sdlp_pkg::OFF_SELF_REFRESH_EXIT: prdata <= {28'h0, srx_r};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	assign irq = stat_r & mask_r;

	// ----------------------------------------
	// Initialization fields toward the memory
	// ----------------------------------------
	assign partial_array_refresh = lpc_r[sdlp_pkg::PAR_LSB +: 3];
	assign temp_comp_refresh = lpc_r[sdlp_pkg::TCR_LSB +: 2];
	assign output_drive_strength = lpc_r[sdlp_pkg::ODS_LSB +: 2];
	assign memory_type = mt_r;

	// ----------------------------------------
	// Low-power sequencing
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_ACTIVE,
		ST_WAIT,
		ST_LOW,
		ST_DEEP,
		ST_EXIT
	} sdlp_state_e;

	sdlp_state_e state_r;
	logic [7:0] idle_r;
	logic [3:0] exit_r;
	logic [1:0] sel;
	logic [1:0] tmo;
	logic [7:0] limit;
	logic deep_ok;
	logic [1:0] lp_sel_r;
	logic [4:0] cke_age_r;

	assign sel = lpc_r[sdlp_pkg::LPS_LSB +: 2];
	assign tmo = lpc_r[sdlp_pkg::TMO_LSB +: 2];
	// Reserved timeout code treated as immediate entry
	assign limit = (tmo == 2'h1) ? sdlp_pkg::ENTRY_SHORT :
		(tmo == 2'h2) ? sdlp_pkg::ENTRY_LONG : 8'h00;
	// Deep power-down is only legal for low-power memories
	assign deep_ok = (mt_r == sdlp_pkg::MT_LP_SDRAM);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_ACTIVE;
			idle_r <= 8'h00;
			exit_r <= 4'h0;
			lp_sel_r <= sdlp_pkg::LPS_NONE;
			lp_cmd <= sdlp_pkg::CMD_NONE;
		end else begin
			lp_cmd <= sdlp_pkg::CMD_NONE;
			case (state_r)
				ST_ACTIVE: begin
					idle_r <= 8'h00;
					if (sel != sdlp_pkg::LPS_NONE && !access_busy && !access_req) begin
						state_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (access_busy || access_req || sel == sdlp_pkg::LPS_NONE) begin
						state_r <= ST_ACTIVE;
					end else if (idle_r >= limit) begin
						case (sel)
							sdlp_pkg::LPS_SELF: begin
								lp_cmd <= sdlp_pkg::CMD_SELF_REFRESH;
								lp_sel_r <= sel;
								state_r <= ST_LOW;
							end
							sdlp_pkg::LPS_PDN: begin
								lp_cmd <= sdlp_pkg::CMD_POWER_DOWN;
								lp_sel_r <= sel;
								state_r <= ST_LOW;
							end
							default: begin
								if (deep_ok) begin
									lp_cmd <= sdlp_pkg::CMD_DEEP_POWER_DOWN;
									lp_sel_r <= sel;
									state_r <= ST_DEEP;
								end
							end
						endcase
					end else begin
						idle_r <= idle_r + 8'h01;
					end
				end
				ST_LOW: begin
					// Leave to serve an access, re-enter once it completes
					// A mode change, 00 included, also wakes the memory
					if (access_req || sel != lp_sel_r) begin
						lp_cmd <= sdlp_pkg::CMD_EXIT;
						exit_r <= srx_r;
						state_r <= ST_EXIT;
					end
				end
				ST_DEEP: begin
					// Only a mode change wakes from deep power-down
					if (sel != sdlp_pkg::LPS_DEEP) begin
						lp_cmd <= sdlp_pkg::CMD_EXIT;
						exit_r <= srx_r;
						state_r <= ST_EXIT;
					end
				end
				ST_EXIT: begin
					if (exit_r == 4'h0) begin
						state_r <= ST_ACTIVE;
					end else begin
						exit_r <= exit_r - 4'h1;
					end
				end
				default: state_r <= ST_ACTIVE;
			endcase
		end
	end

	assign sdram_clock_enable = (state_r == ST_ACTIVE) || (state_r == ST_WAIT)
		|| (state_r == ST_EXIT);
	assign sdram_clock_out_en = !((state_r == ST_LOW && lp_sel_r == sdlp_pkg::LPS_SELF)
		|| state_r == ST_DEEP);
	// Activate held off until the exit delay has run out
	assign access_grant = (state_r == ST_ACTIVE) || (state_r == ST_WAIT);

	// ----------------------------------------
	// Clock-enable age, checks only
	// ----------------------------------------
	// Saturates so a long active stretch cannot wrap back under the delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cke_age_r <= 5'h00;
		end else if (!sdram_clock_enable) begin
			cke_age_r <= 5'h00;
		end else if (cke_age_r != 5'h1f) begin
			cke_age_r <= cke_age_r + 5'h01;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_no_lp_cmd: assert property (@(posedge pclk) disable iff (!presetn)
		$past(sel) == sdlp_pkg::LPS_NONE && sel == sdlp_pkg::LPS_NONE
		|-> lp_cmd == sdlp_pkg::CMD_NONE || lp_cmd == sdlp_pkg::CMD_EXIT)
		else $error("low-power command with feature inhibited");
	chk_self_cke: assert property (@(posedge pclk) disable iff (!presetn)
		lp_cmd == sdlp_pkg::CMD_SELF_REFRESH |-> !sdram_clock_enable && !sdram_clock_out_en)
		else $error("self-refresh without clock stop");
	chk_pdn_cke: assert property (@(posedge pclk) disable iff (!presetn)
		lp_cmd == sdlp_pkg::CMD_POWER_DOWN |-> !sdram_clock_enable)
		else $error("power-down with clock enable high");
	chk_deep_type: assert property (@(posedge pclk) disable iff (!presetn)
		lp_cmd == sdlp_pkg::CMD_DEEP_POWER_DOWN |-> $past(mt_r) == sdlp_pkg::MT_LP_SDRAM)
		else $error("deep power-down to standard memory");
	chk_entry_delay: assert property (@(posedge pclk) disable iff (!presetn)
		lp_cmd == sdlp_pkg::CMD_POWER_DOWN |-> $past(idle_r) >= $past(limit))
		else $error("low-power entry before delay");
	chk_mask_set: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == sdlp_pkg::OFF_INTERRUPT_ENABLE && pwdata[0] |=> mask_r)
		else $error("enable write did not set mask");
	chk_mask_clr: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == sdlp_pkg::OFF_INTERRUPT_DISABLE && pwdata[0]
		&& !(paddr == sdlp_pkg::OFF_INTERRUPT_ENABLE) |=> !mask_r)
		else $error("disable write did not clear mask");
	chk_stat_set: assert property (@(posedge pclk) disable iff (!presetn)
		refresh_error |=> stat_r)
		else $error("refresh error lost");
	chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		stat_r && mask_r |-> irq)
		else $error("interrupt not raised");
	chk_exit_wait: assert property (@(posedge pclk) disable iff (!presetn)
		lp_cmd == sdlp_pkg::CMD_EXIT |-> !access_grant)
		else $error("access granted during exit delay");
	chk_exit_delay: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(access_grant) |-> cke_age_r > {1'b0, srx_r})
		else $error("activate allowed before exit delay ran out");

	chk_irq_low: assert property (@(posedge pclk) disable iff (!presetn)
		!(stat_r && mask_r) |-> !irq)
		else $error("interrupt raised without masked status");
	chk_stat_clear: assert property (@(posedge pclk) disable iff (!presetn)
		rd_en && paddr == sdlp_pkg::OFF_INTERRUPT_STATUS && prdata[sdlp_pkg::RFE_BIT]
		&& !refresh_error |=> !stat_r)
		else $error("status read did not clear");
	chk_stat_hold: assert property (@(posedge pclk) disable iff (!presetn)
		stat_r && !(rd_en && paddr == sdlp_pkg::OFF_INTERRUPT_STATUS) |=> stat_r)
		else $error("status lost without a read");
	chk_mask_read: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && paddr == sdlp_pkg::OFF_INTERRUPT_MASK
		|=> prdata == {31'h0, $past(mask_r)})
		else $error("mask read wrong");
	chk_mask_keep: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_en && (paddr == sdlp_pkg::OFF_INTERRUPT_ENABLE
		|| paddr == sdlp_pkg::OFF_INTERRUPT_DISABLE)) |=> mask_r == $past(mask_r))
		else $error("mask changed without a write");
	chk_mt_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == sdlp_pkg::OFF_MEMORY_TYPE_SELECT |=> mt_r == $past(pwdata[1:0]))
		else $error("memory type write lost");
	chk_lpc_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == sdlp_pkg::OFF_LOW_POWER_CONTROL
		|=> lpc_r == ($past(pwdata) & sdlp_pkg::LPC_WMASK))
		else $error("low-power control write lost");

	chk_cmd_idle: assert property (@(posedge pclk) disable iff (!presetn)
		lp_cmd == sdlp_pkg::CMD_SELF_REFRESH || lp_cmd == sdlp_pkg::CMD_POWER_DOWN
		|-> $past(!access_busy && !access_req))
		else $error("low-power entry during an access");
	chk_wait_hold: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_WAIT && idle_r < limit |=> lp_cmd == sdlp_pkg::CMD_NONE)
		else $error("low-power entry before timeout");
	chk_sel_none: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_ACTIVE && sel == sdlp_pkg::LPS_NONE |=> state_r == ST_ACTIVE)
		else $error("left active state with feature inhibited");
	chk_low_cke: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_LOW || state_r == ST_DEEP |-> !sdram_clock_enable)
		else $error("clock enable high in low power");
	chk_self_clock: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_LOW && lp_sel_r == sdlp_pkg::LPS_SELF |-> !sdram_clock_out_en)
		else $error("memory clock running in self-refresh");
	chk_deep_clock: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_DEEP |-> !sdram_clock_out_en)
		else $error("memory clock running in deep power-down");
	chk_low_wake: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_LOW && access_req |=> lp_cmd == sdlp_pkg::CMD_EXIT)
		else $error("access did not wake the memory");

	cov_self: cover property (@(posedge pclk) disable iff (!presetn)
		lp_cmd == sdlp_pkg::CMD_SELF_REFRESH ##[1:50] lp_cmd == sdlp_pkg::CMD_EXIT);
	cov_pdn: cover property (@(posedge pclk) disable iff (!presetn)
		lp_cmd == sdlp_pkg::CMD_POWER_DOWN);
	cov_deep: cover property (@(posedge pclk) disable iff (!presetn)
		lp_cmd == sdlp_pkg::CMD_DEEP_POWER_DOWN);
	cov_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
	cov_stat_race: cover property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && paddr == sdlp_pkg::OFF_INTERRUPT_STATUS && refresh_error);
endmodule : sdlp_ctrl

// ===== test/sdlp_mem_model.sv
// Far-side model: sequencer and memory asking for and running accesses.
// Assumes the controller grants access through grant and clock enable.
`timescale 1ns/1ps
module sdlp_mem_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic want,
	input wire logic access_grant,
	input wire logic sdram_clock_enable,
	output logic access_req,
	output logic access_busy,
	output logic done
);
	int n;
	// ----------------------------------------
	// Access sequence
	// ----------------------------------------
	// No access starts until grant and clock enable are both high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			access_req <= 1'b0;
			access_busy <= 1'b0;
			done <= 1'b0;
			n <= 0;
		end else begin
			done <= 1'b0;
			if (!access_busy && want && !done)
				access_req <= 1'b1;
			if (access_req && !access_busy && access_grant && sdram_clock_enable) begin
				access_busy <= 1'b1;
				n <= 3;
			end else if (access_busy) begin
				if (n == 1) begin
					access_busy <= 1'b0;
					access_req <= 1'b0;
					done <= 1'b1;
				end
				n <= n - 1;
			end
		end
	end
endmodule : sdlp_mem_model

// ===== test/sdlp_ctrl_tb_top.sv
// Self-checking bench for the low-power, interrupt and memory-type block.
// Assumes the far-side model drives access requests and busy.
`timescale 1ns/1ps
module sdlp_ctrl_tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, refresh_error = 0, want = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, v;
	logic pready, pslverr, access_busy, access_req, access_grant, done, irq;
	logic sdram_clock_out_en, sdram_clock_enable;
	logic [2:0] partial_array_refresh;
	logic [1:0] temp_comp_refresh, output_drive_strength, memory_type;
	sdlp_pkg::sdlp_cmd_e lp_cmd, ec[4];
	int fail_count = 0, compares = 0, cyc = 0, n, d, dly[4] = '{0, 64, 128, 0};
	sdlp_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .access_busy, .access_req, .refresh_error, .access_grant, .lp_cmd,
		.sdram_clock_out_en, .sdram_clock_enable, .partial_array_refresh, .temp_comp_refresh,
		.output_drive_strength, .memory_type, .irq);
	sdlp_mem_model u_mem (.pclk, .presetn, .want, .access_grant, .sdram_clock_enable,
		.access_req, .access_busy, .done);
	initial begin
		forever #5 pclk = ~pclk;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		@(posedge pclk);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= dat; penable <= 0;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(rd, e);
	endtask : rdc
	task automatic err_pulse;
		@(posedge pclk) refresh_error <= 1;
		@(posedge pclk) refresh_error <= 0;
		repeat (2) @(posedge pclk);
		#1;
	endtask : err_pulse
	task automatic results;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	// Hang guard, far above the several hundred cycles the tests need
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			results();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		ec = '{sdlp_pkg::CMD_NONE, sdlp_pkg::CMD_SELF_REFRESH, sdlp_pkg::CMD_POWER_DOWN,
			sdlp_pkg::CMD_DEEP_POWER_DOWN};
		n = $urandom(32'h3e3cc8b4);
		repeat (4) @(posedge pclk);
		presetn <= 1;
		rdc(sdlp_pkg::OFF_LOW_POWER_CONTROL, sdlp_pkg::LPC_RESET);
		rdc(sdlp_pkg::OFF_MEMORY_TYPE_SELECT, {30'h0, sdlp_pkg::MT_RESET});
		rdc(sdlp_pkg::OFF_INTERRUPT_MASK, 32'h0);
		rdc(sdlp_pkg::OFF_SELF_REFRESH_EXIT, {28'h0, sdlp_pkg::SRX_RESET});
		rdc(8'h1c, 32'h0);
		$display("test reset done");
		apb(1, sdlp_pkg::OFF_INTERRUPT_ENABLE, 32'hfffffffe);
		rdc(sdlp_pkg::OFF_INTERRUPT_MASK, 32'h0);
		apb(1, sdlp_pkg::OFF_INTERRUPT_ENABLE, 32'h1);
		rdc(sdlp_pkg::OFF_INTERRUPT_MASK, 32'h1);
		err_pulse();
		chk(irq, 1);
		rdc(sdlp_pkg::OFF_INTERRUPT_STATUS, 32'h1);
		rdc(sdlp_pkg::OFF_INTERRUPT_STATUS, 32'h0);
		chk(irq, 0);
		apb(1, sdlp_pkg::OFF_INTERRUPT_DISABLE, 32'hfffffffe);
		rdc(sdlp_pkg::OFF_INTERRUPT_MASK, 32'h1);
		apb(1, sdlp_pkg::OFF_INTERRUPT_DISABLE, 32'h1);
		rdc(sdlp_pkg::OFF_INTERRUPT_MASK, 32'h0);
		err_pulse();
		chk(irq, 0);
		rdc(sdlp_pkg::OFF_INTERRUPT_STATUS, 32'h1);
		fork
			rdc(sdlp_pkg::OFF_INTERRUPT_STATUS, 32'h0);
			begin
				@(posedge pclk) refresh_error <= 1;
				@(posedge pclk) refresh_error <= 0;
			end
		join
		rdc(sdlp_pkg::OFF_INTERRUPT_STATUS, 32'h1);
		$display("test interrupt done");
		apb(1, sdlp_pkg::OFF_MEMORY_TYPE_SELECT, {30'h0, sdlp_pkg::MT_LP_SDRAM});
		rdc(sdlp_pkg::OFF_MEMORY_TYPE_SELECT, 32'h1);
		chk(memory_type, sdlp_pkg::MT_LP_SDRAM);
		for (int s = 0; s < 4; s++) begin
			v = ($urandom & sdlp_pkg::LPC_WMASK & ~32'h3003) | s | ((s % 3) << 12);
			apb(1, sdlp_pkg::OFF_LOW_POWER_CONTROL, v);
			rdc(sdlp_pkg::OFF_LOW_POWER_CONTROL, v);
			chk(partial_array_refresh, v[6:4]);
			chk(temp_comp_refresh, v[9:8]);
			chk(output_drive_strength, v[11:10]);
			// Bank choice of extended-mode writes is software's, not driven here
			want <= 1;
			for (int k = 0; k < 300 && done !== 1'b1; k++) @(posedge pclk) #1;
			@(posedge pclk);
			want <= 0;
			n = -1;
			for (int k = 0; k < 300 && n < 0; k++) begin
				@(posedge pclk) #1;
				if (lp_cmd !== sdlp_pkg::CMD_NONE)
					n = k;
			end
			chk(lp_cmd, ec[s]);
			if (s != 0) begin
				d = dly[s];
				chk(n >= d - 2 && n <= d + 3, 1);
				@(posedge pclk) #1;
				chk(sdram_clock_enable, 0);
				if (s == 1)
					chk(sdram_clock_out_en, 0);
			end
			$display("test low-power select %0d done", s);
		end
		results();
	end
endmodule : sdlp_ctrl_tb_top
